/* File: hw/lcd_cmd_pkg.sv */
// Constants and types for the indirect command decoder
// Overview of operation
// - Initialisation command byte leaves power save.
// - Eight initialisation parameters follow; after the eighth, normal operation.
// - First init parameter bit 5 goes to config zero bit 5.
// - First init parameter bit 3 is panel drive select; one is dual.
// - First init parameter bit 2 goes to config zero bit 2.
// - First init parameter bit 0 stored; bits 7, 6, 4, 1 forced zero.
// - Second init parameter keeps bit 7 and bits 3-0; bits 6-4 zero.
// - Standby command has no parameters and enters power save.
// - Display enable takes one parameter into display attribute register.
// - Display disable likewise takes one parameter into same register.
// - Scroll parameters fill consecutive registers from 0Bh in order.
// - Cursor shape takes two parameters; low nibbles give sizes.
// - Second cursor shape parameter bit 7 is cursor mode; bits 6-4 zero.
// - Cursor direction has no parameters; command bits 1-0 go to 17h.
// - Overlay parameter bit 4 is three-layer select; bits 7-5 zero.
// - Overlay parameter bits 3-2 are block display modes.
// - Overlay parameter bits 1-0 are layer composition method.
// - Initialisation code 40h; parameters stored at indices 00h to 07h.
// - Display enable code 59h, disable code 58h, one parameter each.
// - Scroll code 44h, up to ten parameters.
// - Overlay code 5Bh, one parameter.
package lcd_cmd_pkg;

  localparam int unsigned REG_COUNT = 25;
  localparam int unsigned IDX_W     = 5;

  // Command codes
  localparam logic [7:0] CMD_INIT     = 8'h40;
  localparam logic [7:0] CMD_STANDBY  = 8'h53;
  localparam logic [7:0] CMD_DISPLAY_DISABLE_COMMAND = 8'h58;
  localparam logic [7:0] CMD_DISPLAY_ENABLE_COMMAND  = 8'h59;
  localparam logic [7:0] CMD_SCROLL   = 8'h44;
  localparam logic [7:0] CMD_CSR_SHP  = 8'h5D;
  localparam logic [7:0] CMD_OVERLAY  = 8'h5B;
  localparam logic [7:0] CMD_CSR_DIR  = 8'h4C;
  localparam logic [7:0] CSR_DIR_MASK = 8'hFC;

  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_CFG0    = 5'h00;
  localparam logic [IDX_W-1:0] IDX_CFG1    = 5'h01;
  localparam logic [IDX_W-1:0] IDX_DISP    = 5'h0A;
  localparam logic [IDX_W-1:0] IDX_SCROLL  = 5'h0B;
  localparam logic [IDX_W-1:0] IDX_CSR_X   = 5'h15;
  localparam logic [IDX_W-1:0] IDX_CSR_Y   = 5'h16;
  localparam logic [IDX_W-1:0] IDX_CSR_DIR = 5'h17;
  localparam logic [IDX_W-1:0] IDX_OVERLAY = 5'h18;

  // Parameter counts
  localparam logic [3:0] NP_INIT    = 4'h8;
  localparam logic [3:0] NP_DISP    = 4'h1;
  localparam logic [3:0] NP_SCROLL  = 4'hA;
  localparam logic [3:0] NP_CSR_SHP = 4'h2;
  localparam logic [3:0] NP_OVERLAY = 4'h1;

  // Write masks; cleared bits are stored as zero
  localparam logic [7:0] MASK_CFG0    = 8'h2D;
  localparam logic [7:0] MASK_CFG1    = 8'h8F;
  localparam logic [7:0] MASK_CSR_X   = 8'h0F;
  localparam logic [7:0] MASK_CSR_Y   = 8'h8F;
  localparam logic [7:0] MASK_CSR_DIR = 8'h03;
  localparam logic [7:0] MASK_OVERLAY = 8'h1F;
  localparam logic [7:0] MASK_FULL    = 8'hFF;

  // Own control and status registers
  localparam logic [IDX_W-1:0] IDX_CMD    = 5'h1C;
  localparam logic [IDX_W-1:0] IDX_PARAM  = 5'h1D;
  localparam logic [IDX_W-1:0] IDX_STATUS = 5'h1E;

  // Status bits
  localparam int unsigned ST_PSAVE  = 0;
  localparam int unsigned ST_NORMAL = 1;

  // Bus address layout
  localparam int unsigned ADDR_W = 7;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_INIT,
    OP_DISP,
    OP_SCROLL,
    OP_CSR_SHP,
    OP_OVERLAY
  } op_e;

  typedef struct packed {
    logic                  write;
    logic [IDX_W-1:0]      index;
    logic [7:0]            data;
  } reg_wr_s;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [ADDR_W-1:0]     address;
    logic [31:0]           writedata;
  } avalon_req_s;

endpackage

/* File: hw/lcd_cfg_mem.sv */
// Configuration register storage with registered read data
`timescale 1ns/1ns
`default_nettype none

module lcd_cfg_mem
(
  input  wire logic                          clock_in,
  input  wire logic                          rst_b_in,
  input  wire lcd_cmd_pkg::reg_wr_s          wr_in,
  input  wire logic [lcd_cmd_pkg::IDX_W-1:0] rd_index_in,
  output logic [7:0]                         rd_data_out,
  output logic [7:0]                         cfg0_out
);

  logic [7:0] mem [lcd_cmd_pkg::REG_COUNT];

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < lcd_cmd_pkg::REG_COUNT; i++)
        mem[i] <= 8'h00;
      rd_data_out <= 8'h00;
      cfg0_out    <= 8'h00;
    end
    else
    begin
      if (wr_in.write && (wr_in.index < lcd_cmd_pkg::REG_COUNT))
        mem[wr_in.index] <= wr_in.data;
      if (wr_in.write && (wr_in.index == lcd_cmd_pkg::IDX_CFG0))
        cfg0_out <= wr_in.data;
      if (rd_index_in < lcd_cmd_pkg::REG_COUNT)
        rd_data_out <= mem[rd_index_in];
      else
        rd_data_out <= 8'h00;
    end
  end

endmodule

`default_nettype wire

/* File: hw/lcd_cmd_decoder.sv */
// Indirect command decoder with Avalon-MM register access
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module lcd_ctrl_indirect_cmd_decoder
(
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic [6:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             power_save_out,
  output logic             normal_mode_out,
  output logic             dual_panel_out
);

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_MEM,
    BUS_DONE
  } bus_e;

  typedef struct packed {
    bus_e                          bus;
    lcd_cmd_pkg::op_e              op;
    logic [3:0]                    count;
    logic                          psave;
    logic                          normal;
    logic [31:0]                   rdata;
    logic                          wait_n;
  } state_s;

  state_s               st;
  state_s               next_st;
  lcd_cmd_pkg::reg_wr_s next_wr;
  lcd_cmd_pkg::reg_wr_s wr;
  logic [7:0]           mem_rdata;
  logic [7:0]           cfg0;
  logic [lcd_cmd_pkg::IDX_W-1:0] rd_index;
  logic [lcd_cmd_pkg::IDX_W-1:0] req_index;
  logic [7:0]           byte_in;

  // Parameter count for an operation
  function automatic logic [3:0] param_limit(input lcd_cmd_pkg::op_e op);
    case (op)
      lcd_cmd_pkg::OP_INIT:    param_limit = lcd_cmd_pkg::NP_INIT;
      lcd_cmd_pkg::OP_DISP:    param_limit = lcd_cmd_pkg::NP_DISP;
      lcd_cmd_pkg::OP_SCROLL:  param_limit = lcd_cmd_pkg::NP_SCROLL;
      lcd_cmd_pkg::OP_CSR_SHP: param_limit = lcd_cmd_pkg::NP_CSR_SHP;
      lcd_cmd_pkg::OP_OVERLAY: param_limit = lcd_cmd_pkg::NP_OVERLAY;
      default:                 param_limit = 4'h0;
    endcase
  endfunction

  // First register of an operation's sequence
  function automatic logic [lcd_cmd_pkg::IDX_W-1:0] base_index(
    input lcd_cmd_pkg::op_e op);
    case (op)
      lcd_cmd_pkg::OP_INIT:    base_index = lcd_cmd_pkg::IDX_CFG0;
      lcd_cmd_pkg::OP_DISP:    base_index = lcd_cmd_pkg::IDX_DISP;
      lcd_cmd_pkg::OP_SCROLL:  base_index = lcd_cmd_pkg::IDX_SCROLL;
      lcd_cmd_pkg::OP_CSR_SHP: base_index = lcd_cmd_pkg::IDX_CSR_X;
      lcd_cmd_pkg::OP_OVERLAY: base_index = lcd_cmd_pkg::IDX_OVERLAY;
      default:                 base_index = lcd_cmd_pkg::IDX_CFG0;
    endcase
  endfunction

  // Bits kept when a byte lands in a register
  function automatic logic [7:0] field_mask(
    input logic [lcd_cmd_pkg::IDX_W-1:0] idx);
    if (idx == lcd_cmd_pkg::IDX_CFG0)
      field_mask = lcd_cmd_pkg::MASK_CFG0;
    else if (idx == lcd_cmd_pkg::IDX_CFG1)
      field_mask = lcd_cmd_pkg::MASK_CFG1;
    else if (idx == lcd_cmd_pkg::IDX_CSR_X)
      field_mask = lcd_cmd_pkg::MASK_CSR_X;
    else if (idx == lcd_cmd_pkg::IDX_CSR_Y)
      field_mask = lcd_cmd_pkg::MASK_CSR_Y;
    else if (idx == lcd_cmd_pkg::IDX_OVERLAY)
      field_mask = lcd_cmd_pkg::MASK_OVERLAY;
    else
      field_mask = lcd_cmd_pkg::MASK_FULL;
  endfunction

  assign req_index = avs_address_in[lcd_cmd_pkg::IDX_W+1:2];
  assign byte_in   = avs_writedata_in[7:0];
  assign rd_index  = req_index;

  lcd_cfg_mem u_mem
  (
    .clock_in    (clock_in),
    .rst_b_in    (rst_b_in),
    .wr_in       (wr),
    .rd_index_in (rd_index),
    .rd_data_out (mem_rdata),
    .cfg0_out    (cfg0)
  );

  always_comb
  begin
    next_st       = st;
    next_wr       = '0;
    next_st.wait_n = 1'b0;
    case (st.bus)
      BUS_IDLE:
      begin
        if (avs_write_in)
        begin
          next_st.bus    = BUS_DONE;
          next_st.wait_n = 1'b1;
          if (req_index == lcd_cmd_pkg::IDX_CMD)
          begin
            next_st.count = 4'h0;
            next_st.op    = lcd_cmd_pkg::OP_NONE;
            if (byte_in == lcd_cmd_pkg::CMD_INIT)
            begin
              next_st.op    = lcd_cmd_pkg::OP_INIT;
              next_st.psave = 1'b0;
            end
            else if (byte_in == lcd_cmd_pkg::CMD_STANDBY)
            begin
              next_st.psave  = 1'b1;
              next_st.normal = 1'b0;
            end
            else if (byte_in == lcd_cmd_pkg::CMD_DISPLAY_ENABLE_COMMAND ||
                     byte_in == lcd_cmd_pkg::CMD_DISPLAY_DISABLE_COMMAND)
              next_st.op = lcd_cmd_pkg::OP_DISP;
            else if (byte_in == lcd_cmd_pkg::CMD_SCROLL)
              next_st.op = lcd_cmd_pkg::OP_SCROLL;
            else if (byte_in == lcd_cmd_pkg::CMD_CSR_SHP)
              next_st.op = lcd_cmd_pkg::OP_CSR_SHP;
            else if (byte_in == lcd_cmd_pkg::CMD_OVERLAY)
              next_st.op = lcd_cmd_pkg::OP_OVERLAY;
            else if ((byte_in & lcd_cmd_pkg::CSR_DIR_MASK) ==
                     lcd_cmd_pkg::CMD_CSR_DIR)
            begin
              next_wr.write = 1'b1;
              next_wr.index = lcd_cmd_pkg::IDX_CSR_DIR;
              next_wr.data  = byte_in & lcd_cmd_pkg::MASK_CSR_DIR;
            end
          end
          else if (req_index == lcd_cmd_pkg::IDX_PARAM)
          begin
            if (st.op != lcd_cmd_pkg::OP_NONE &&
                st.count < param_limit(st.op))
            begin
              next_wr.write = 1'b1;
              next_wr.index = base_index(st.op) +
                              lcd_cmd_pkg::IDX_W'(st.count);
              next_wr.data  = byte_in & field_mask(next_wr.index);
              next_st.count = st.count + 4'h1;
              if (st.op == lcd_cmd_pkg::OP_INIT &&
                  st.count == lcd_cmd_pkg::NP_INIT - 4'h1)
                next_st.normal = 1'b1;
            end
          end
        end
        else if (avs_read_in)
        begin
          if (req_index < lcd_cmd_pkg::REG_COUNT)
            next_st.bus = BUS_MEM;
          else
          begin
            next_st.bus    = BUS_DONE;
            next_st.wait_n = 1'b1;
            next_st.rdata  = '0;
            if (req_index == lcd_cmd_pkg::IDX_STATUS)
            begin
              next_st.rdata[lcd_cmd_pkg::ST_PSAVE]  = st.psave;
              next_st.rdata[lcd_cmd_pkg::ST_NORMAL] = st.normal;
            end
          end
        end
      end
      BUS_MEM:
      begin
        next_st.bus    = BUS_DONE;
        next_st.wait_n = 1'b1;
        next_st.rdata  = {24'h00_0000, mem_rdata};
      end
      default:
        next_st.bus = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st       <= '0;
      st.psave <= 1'b1;
      wr       <= '0;
    end
    else
    begin
      st <= next_st;
      wr <= next_wr;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      avs_readdata_out    <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
      power_save_out      <= 1'b1;
      normal_mode_out     <= 1'b0;
      dual_panel_out      <= 1'b0;
    end
    else
    begin
      avs_readdata_out    <= next_st.rdata;
      avs_waitrequest_out <= ~next_st.wait_n;
      power_save_out      <= next_st.psave;
      normal_mode_out     <= next_st.normal;
      dual_panel_out      <= cfg0[3];
    end
  end

endmodule

`default_nettype wire

/* File: bench/lcd_cmd_properties.sv */
// Port checks for the command decoder
`timescale 1ns/1ns
`default_nettype none
module lcd_cmd_checker
(
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic [6:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        power_save_out,
  input wire logic        normal_mode_out,
  input wire logic        dual_panel_out
);
  default clocking dc @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  wire logic       ack_cmd;
  wire logic [7:0] cmd;
  assign ack_cmd = avs_write_in && !avs_waitrequest_out
    && avs_address_in == 7'h70;
  assign cmd = avs_writedata_in[7:0];
  a_ack_single: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("ack too long");
  a_write_ack: assert property (
    $rose(avs_write_in) |=> !avs_waitrequest_out)
    else $error("write ack late");
  a_read_cfg: assert property (
    $rose(avs_read_in) && avs_address_in < 7'h64
    |=> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read ack timing");
  a_standby_enter: assert property (
    ack_cmd && cmd == 8'h53 |-> ##[1:2] power_save_out && !normal_mode_out)
    else $error("no power save");
  a_init_wake: assert property (
    ack_cmd && cmd == 8'h40 |-> ##[1:2] !power_save_out)
    else $error("no wake");
  a_normal_awake: assert property (
    $rose(normal_mode_out) |-> !power_save_out)
    else $error("normal in power save");
  a_psave_cause: assert property (
    $changed(power_save_out) |-> ack_cmd)
    else $error("power save changed alone");
  a_dual_cause: assert property (
    $changed(dual_panel_out)
    |-> $past(avs_write_in, 2) || $past(avs_write_in, 3))
    else $error("dual panel changed alone");
endmodule
bind lcd_ctrl_indirect_cmd_decoder lcd_cmd_checker chk
  (.clock_in(clock_in), .rst_b_in(rst_b_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .power_save_out(power_save_out), .normal_mode_out(normal_mode_out),
  .dual_panel_out(dual_panel_out));
`default_nettype wire

/* File: bench/lcd_host_model.sv */
// Avalon-MM host issuing command and parameter bytes
`timescale 1ns/1ns
`default_nettype none
module lcd_host_model
(
  input  wire logic        clock_in,
  input  wire logic        waitrequest_in,
  input  wire logic [31:0] readdata_in,
  output logic [6:0]       address_out,
  output logic             read_out,
  output logic             write_out,
  output logic [31:0]      writedata_out
);
  initial
  begin
    address_out = 7'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0000_0000;
  end
  task automatic xfer(input logic rd, input logic [6:0] a,
    input logic [7:0] d, input int gap, output logic [31:0] q);
    repeat (gap) @(posedge clock_in);
    @(posedge clock_in);
    read_out <= rd;
    write_out <= !rd;
    address_out <= a;
    writedata_out <= {24'h00_0000, d};
    do
      @(posedge clock_in);
    while (waitrequest_in !== 1'b0);
    q = readdata_in;
    read_out <= 1'b0;
    write_out <= 1'b0;
    // Released lines show no stale value
    address_out <= ~a;
    writedata_out <= ~writedata_out;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the command decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  logic        clock_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [6:0]  adr;
  logic        rd, wr_en, wait_r, psave, normal, dual;
  logic [31:0] wdata, rdata;
  int          errors = 0;
  int          check_count = 0;
  always #2 clock_in = ~clock_in;
  lcd_ctrl_indirect_cmd_decoder dut (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
    .power_save_out(psave), .normal_mode_out(normal),
    .dual_panel_out(dual));
  lcd_host_model host (.clock_in(clock_in), .waitrequest_in(wait_r),
    .readdata_in(rdata), .address_out(adr), .read_out(rd),
    .write_out(wr_en), .writedata_out(wdata));
  task automatic w(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] q;
    host.xfer(1'b0, a, d, 0, q);
  endtask
  task automatic r(input logic [4:0] i, input logic [7:0] e);
    logic [31:0] q;
    host.xfer(1'b1, {i, 2'b00}, 8'h00, 0, q);
    `CHK(q, {24'h00_0000, e})
  endtask
  task automatic t_init;
    `CHK({psave, normal, dual}, 3'b100)
    r(5'h1F, 8'h00);
    w(7'h70, 8'h40);
    r(5'h1E, 8'h00);
    w(7'h74, 8'hFF);
    w(7'h74, 8'hFF);
    for (int i = 2; i < 7; i++)
      w(7'h74, 8'h10 + 8'(i));
    `CHK(normal, 1'b0)
    w(7'h74, 8'h17);
    w(7'h74, 8'h55);
    `CHK({psave, normal, dual}, 3'b011)
    r(5'h00, 8'h2D);
    r(5'h01, 8'h8F);
    for (int i = 2; i < 8; i++)
      r(5'(i), 8'h10 + 8'(i));
    r(5'h08, 8'h00);
  endtask
  task automatic t_standby;
    w(7'h70, 8'h53);
    r(5'h1E, 8'h01);
    w(7'h70, 8'h40);
    r(5'h1E, 8'h00);
  endtask
  task automatic t_disp;
    for (int k = 0; k < 2; k++)
    begin
      w(7'h70, 8'h58 + 8'(k));
      w(7'h74, 8'hA5 ^ 8'(k));
      r(5'h0A, 8'hA5 ^ 8'(k));
    end
  endtask
  task automatic t_scroll;
    w(7'h70, 8'h44);
    for (int i = 0; i < 10; i++)
      w(7'h74, 8'h30 + 8'(i));
    w(7'h74, 8'hEE);
    for (int i = 0; i < 10; i++)
      r(5'h0B + 5'(i), 8'h30 + 8'(i));
    r(5'h15, 8'h00);
    w(7'h70, 8'h44);
    w(7'h74, 8'hC0);
    w(7'h70, 8'h44);
    w(7'h74, 8'hC1);
    r(5'h0B, 8'hC1);
    r(5'h0C, 8'h31);
  endtask
  task automatic t_cursor;
    logic [31:0] q;
    w(7'h70, 8'h5D);
    host.xfer(1'b0, 7'h74, 8'hFF, 5, q);
    host.xfer(1'b0, 7'h74, 8'hFF, 5, q);
    r(5'h15, 8'h0F);
    r(5'h16, 8'h8F);
    for (int k = 0; k < 4; k++)
    begin
      w(7'h70, 8'h4C + 8'(k));
      r(5'h17, 8'(k));
    end
    w(7'h70, 8'h5B);
    w(7'h74, 8'hFF);
    w(7'h74, 8'h00);
    r(5'h18, 8'h1F);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    t_init();
    t_standby();
    t_disp();
    t_scroll();
    t_cursor();
    give_verdict();
  end
  initial
  begin
    repeat (4000) @(posedge clock_in);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
